// File: hdl/sdc_config_top.v
// configuration latches, serial loader, power-down stepper and dividers
//
// Functional notes
// - seven-bit feedback value and two-bit post select come from parallel pins
// - parallel inputs are captured on the rising edge of the parallel load
// - parallel path wins over serial path when both drive the latches
// - latches follow parallel pins while parallel load is low; host holds data
// - serial path uses a twelve-bit shift register
// - shift register moves one bit per serial clock rising edge, sampling data
// - serial load falling edge freezes the shift register copy in the latches
// - latches follow shift register while serial load is high; host holds data
// - three-bit test field in the serial word selects the diagnostic output
// - power-down request adds an extra divide by sixteen, glitch-free except with select 11 (/1)
// - power-down stepping is paced by the reference clock edges
// - sixteen-fold change happens in four steps, both down and back up
// - post divider offers divide by one, two, four or eight at 50% duty
// - feedback divider uses programmed value so vco equals value times reference
// - select 00 is /2, 01 /4, 10 /8, 11 /1; power-down multiplies by sixteen
`include "sdc_defines.vh"

module sdc_config_top #(
	parameter FB_W = `SDC_FB_W,
	parameter SHIFT_W = `SDC_SHIFT_W,
	parameter MON_W = 10
) (
	input wire sys_clk,
	input wire reset,
	input wire ref_clk,
	input wire vco_clk,
	input wire serial_clock,
	input wire serial_data,
	input wire serial_load,
	input wire parallel_load,
	input wire [FB_W-1:0] feedback_div_in,
	input wire [`SDC_POST_W-1:0] post_div_sel_in,
	input wire frequency_reduce_request,
	output reg [FB_W-1:0] feedback_div_value,
	output reg [`SDC_POST_W-1:0] post_div_sel,
	output reg [`SDC_TEST_W-1:0] test_sel,
	output reg [`SDC_EXP_W-1:0] freq_step,
	output wire [`SDC_EXP_W-1:0] active_exp,
	output wire synthesized_output,
	output reg feedback_tick,
	output reg [MON_W-1:0] vco_per_ref,
	output reg test_output
);

	// synchroniser chain: meta stage feeds only the sync stage
	reg [`SDC_SYNC_W-1:0] pins_meta_reg;
	reg [`SDC_SYNC_W-1:0] pins_sync_reg;
	// previous sampled levels of the three clock-like pins
	reg ref_prev_reg;
	reg vco_prev_reg;
	reg sclk_prev_reg;

	// serial shift register
	reg [SHIFT_W-1:0] shift_reg;

	// feedback divider state
	reg [FB_W-1:0] fb_cnt_reg;
	reg fb_phase_reg;

	// frequency monitor state
	reg [MON_W-1:0] mon_cnt_reg;

	// decoded and combined divide exponent
	reg [`SDC_EXP_W-1:0] base_exp;
	reg [`SDC_EXP_W-1:0] total_exp;
	reg test_next;

	wire ref_s;
	wire vco_s;
	wire sclk_s;
	wire sdata_s;
	wire sload_s;
	wire pload_s;
	wire reduce_s;
	wire [FB_W-1:0] fb_pins_s;
	wire [`SDC_POST_W-1:0] post_pins_s;
	wire ref_rise;
	wire vco_rise;
	wire sclk_rise;
	wire [FB_W-1:0] fb_last;
	wire [MON_W-1:0] mon_inc;

	assign ref_s = pins_sync_reg[`SDC_SY_REF];
	assign vco_s = pins_sync_reg[`SDC_SY_VCO];
	assign sclk_s = pins_sync_reg[`SDC_SY_SCLK];
	assign sdata_s = pins_sync_reg[`SDC_SY_SDATA];
	assign sload_s = pins_sync_reg[`SDC_SY_SLOAD];
	assign pload_s = pins_sync_reg[`SDC_SY_PLOAD];
	assign reduce_s = pins_sync_reg[`SDC_SY_REDUCE];
	assign post_pins_s = pins_sync_reg[FB_W+`SDC_POST_W-1:FB_W];
	assign fb_pins_s = pins_sync_reg[FB_W-1:0];

	// edges are found on the second stage only, never on the meta stage
	assign ref_rise = ref_s && !ref_prev_reg;
	assign vco_rise = vco_s && !vco_prev_reg;
	assign sclk_rise = sclk_s && !sclk_prev_reg;

	// a programmed value of zero wraps to 127, i.e. divide by 128
	assign fb_last = feedback_div_value - {{(FB_W-1){1'b0}}, 1'b1};
	assign mon_inc = mon_cnt_reg + {{(MON_W-1){1'b0}}, 1'b1};

	// every pin is asynchronous to sys_clk, so all pass two flip-flops
	always @(posedge sys_clk) begin
		if (reset) begin
			pins_meta_reg <= {`SDC_SYNC_W{1'b0}};
			pins_sync_reg <= {`SDC_SYNC_W{1'b0}};
			ref_prev_reg <= 1'b0;
			vco_prev_reg <= 1'b0;
			sclk_prev_reg <= 1'b0;
		end else begin
			pins_meta_reg <= {ref_clk, vco_clk, serial_clock, serial_data, serial_load,
				parallel_load, frequency_reduce_request, post_div_sel_in, feedback_div_in};
			pins_sync_reg <= pins_meta_reg;
			ref_prev_reg <= ref_s;
			vco_prev_reg <= vco_s;
			sclk_prev_reg <= sclk_s;
		end
	end

	// serial shifter: msb first, new bit enters at bit 0
	always @(posedge sys_clk) begin
		if (reset) begin
			shift_reg <= `SDC_SHIFT_RST;
		end else if (sclk_rise) begin
			shift_reg <= {shift_reg[SHIFT_W-2:0], sdata_s};
		end
	end

	// configuration latches, modelled as enabled registers on sys_clk;
	// the held value is the one seen just before the controlling edge,
	// so host data must be stable across that edge plus two sys_clk
	always @(posedge sys_clk) begin
		if (reset) begin
			feedback_div_value <= `SDC_FB_RST;
			post_div_sel <= `SDC_POST_RST;
			test_sel <= `SDC_TEST_RST;
		end else if (!pload_s) begin
			feedback_div_value <= fb_pins_s;
			post_div_sel <= post_pins_s;
		end else if (sload_s) begin
			feedback_div_value <= shift_reg[`SDC_FB_MSB:`SDC_FB_LSB];
			post_div_sel <= shift_reg[`SDC_POST_MSB:`SDC_POST_LSB];
			test_sel <= shift_reg[`SDC_TEST_MSB:`SDC_TEST_LSB];
		end
	end

	// power-down stepper: one halving or doubling per reference edge
	always @(posedge sys_clk) begin
		if (reset) begin
			freq_step <= 3'h0;
		end else if (ref_rise) begin
			if (reduce_s && (freq_step != `SDC_PD_STEPS)) begin
				freq_step <= freq_step + 3'h1;
			end else if (!reduce_s && (freq_step != 3'h0)) begin
				freq_step <= freq_step - 3'h1;
			end
		end
	end

	// select code to base exponent
	always @* begin
		case (post_div_sel)
			`SDC_POST_DIV2: base_exp = `SDC_EXP_DIV2;
			`SDC_POST_DIV4: base_exp = `SDC_EXP_DIV4;
			`SDC_POST_DIV8: base_exp = `SDC_EXP_DIV8;
			`SDC_POST_DIV1: base_exp = `SDC_EXP_DIV1;
			default: base_exp = `SDC_EXP_DIV1;
		endcase
		// each step is one factor of two
		// up to four extra halvings, sixteen in all
		total_exp = base_exp + freq_step;
	end

	// output divider; ratio changes are deferred to a counter wrap
	// so the output sees a runt pulse only on a switch to or from divide by one, at the cost of a delay
	// of up to 128 vco edges before a new ratio shows
	// glitch-free 50% divider
	sdc_step_div #(
		.EXP_W(`SDC_EXP_W),
		.CNT_W(`SDC_CNT_W)
	) u_post_div (
		.sys_clk(sys_clk),
		.reset(reset),
		.tick(vco_rise),
		.src_level(vco_s),
		.exp_req(total_exp),
		.div_out(synthesized_output),
		.exp_active(active_exp)
	);

	// feedback divider: one tick every programmed number of vco edges
	always @(posedge sys_clk) begin
		if (reset) begin
			fb_cnt_reg <= {FB_W{1'b0}};
			fb_phase_reg <= 1'b0;
			feedback_tick <= 1'b0;
		end else begin
			feedback_tick <= 1'b0;
			if (vco_rise) begin
				if (fb_cnt_reg == fb_last) begin
					fb_cnt_reg <= {FB_W{1'b0}};
					fb_phase_reg <= !fb_phase_reg;
					feedback_tick <= 1'b1;
				end else begin
					fb_cnt_reg <= fb_cnt_reg + {{(FB_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end

	// frequency monitor: vco edges counted per reference period, which
	// equals the feedback value once the loop has settled
	always @(posedge sys_clk) begin
		if (reset) begin
			mon_cnt_reg <= {MON_W{1'b0}};
			vco_per_ref <= {MON_W{1'b0}};
		end else if (ref_rise) begin
			vco_per_ref <= vco_rise ? mon_inc : mon_cnt_reg;
			mon_cnt_reg <= {MON_W{1'b0}};
		end else if (vco_rise && !(&mon_cnt_reg)) begin
			mon_cnt_reg <= mon_inc;
		end
	end

	// diagnostic output mux; code 0 keeps the pin still to avoid jitter
	always @* begin
		case (test_sel)
			`SDC_TEST_QUIET: test_next = 1'b0;
			`SDC_TEST_SHIFT: test_next = shift_reg[SHIFT_W-1];
			`SDC_TEST_REF: test_next = ref_s;
			`SDC_TEST_FB: test_next = fb_phase_reg;
			`SDC_TEST_OUT: test_next = synthesized_output;
			`SDC_TEST_STEP: test_next = (freq_step != 3'h0);
			`SDC_TEST_HIGH: test_next = 1'b1;
			`SDC_TEST_LOW: test_next = 1'b0;
			default: test_next = 1'b0;
		endcase
	end

	// registered so the pin never glitches between mux inputs
	always @(posedge sys_clk) begin
		if (reset) begin
			test_output <= 1'b0;
		end else begin
			test_output <= test_next;
		end
	end

endmodule

// File: hdl/sdc_defines.vh
// constants for the synthesizer divider configuration logic
`ifndef SDC_DEFINES_VH
`define SDC_DEFINES_VH

// configuration field widths
`define SDC_FB_W 7
`define SDC_POST_W 2
`define SDC_TEST_W 3
`define SDC_SHIFT_W 12
`define SDC_EXP_W 3
`define SDC_CNT_W 7

// serial word layout, first bit shifted in ends up in bit 11
`define SDC_TEST_MSB 11
`define SDC_TEST_LSB 9
`define SDC_POST_MSB 8
`define SDC_POST_LSB 7
`define SDC_FB_MSB 6
`define SDC_FB_LSB 0

// reset values, matching the pulled-up parallel pins
`define SDC_FB_RST 7'h7f
`define SDC_POST_RST 2'h3
`define SDC_TEST_RST 3'h0
`define SDC_SHIFT_RST 12'h000

// post-divide select codes
`define SDC_POST_DIV2 2'h0
`define SDC_POST_DIV4 2'h1
`define SDC_POST_DIV8 2'h2
`define SDC_POST_DIV1 2'h3

// divide exponents (ratio is two to this power)
`define SDC_EXP_DIV1 3'h0
`define SDC_EXP_DIV2 3'h1
`define SDC_EXP_DIV4 3'h2
`define SDC_EXP_DIV8 3'h3

// power-down sequence: four halvings give the extra divide by sixteen
`define SDC_PD_STEPS 3'h4

// diagnostic output selections
`define SDC_TEST_QUIET 3'h0
`define SDC_TEST_SHIFT 3'h1
`define SDC_TEST_REF 3'h2
`define SDC_TEST_FB 3'h3
`define SDC_TEST_OUT 3'h4
`define SDC_TEST_STEP 3'h5
`define SDC_TEST_HIGH 3'h6
`define SDC_TEST_LOW 3'h7

// synchroniser vector width and bit positions
`define SDC_SYNC_W 16
`define SDC_SY_REF 15
`define SDC_SY_VCO 14
`define SDC_SY_SCLK 13
`define SDC_SY_SDATA 12
`define SDC_SY_SLOAD 11
`define SDC_SY_PLOAD 10
`define SDC_SY_REDUCE 9

`endif

// File: hdl/sdc_step_div.v
// power-of-two divider with 50% duty and change of ratio only at wrap
`include "sdc_defines.vh"

module sdc_step_div #(
	parameter EXP_W = 3,
	parameter CNT_W = 7
) (
	input wire sys_clk,
	input wire reset,
	input wire tick,
	input wire src_level,
	input wire [EXP_W-1:0] exp_req,
	output reg div_out,
	output reg [EXP_W-1:0] exp_active
);

	reg [CNT_W-1:0] cnt_reg;
	reg [CNT_W-1:0] cnt_next;
	reg div_next;
	wire [EXP_W-1:0] exp_m1;
	wire [CNT_W-1:0] shifted;
	wire wrap;

	assign exp_m1 = exp_active - {{(EXP_W-1){1'b0}}, 1'b1};
	assign shifted = cnt_next >> exp_m1;
	assign wrap = tick && (&cnt_reg);

	// counter bit k toggles every 2^k source edges, giving 50% duty
	always @* begin
		cnt_next = cnt_reg;
		if (tick) begin
			cnt_next = cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
		end
		if (exp_active == {EXP_W{1'b0}}) begin
			div_next = src_level;
		end else begin
			div_next = shifted[0];
		end
	end

	// new ratio taken only when every counter bit returns to zero,
	// so no output phase is cut short except on a switch to or from divide by one
	always @(posedge sys_clk) begin
		if (reset) begin
			cnt_reg <= {CNT_W{1'b0}};
			div_out <= 1'b0;
			exp_active <= {EXP_W{1'b0}};
		end else begin
			cnt_reg <= cnt_next;
			div_out <= div_next;
			if (wrap) begin
				exp_active <= exp_req;
			end
		end
	end

endmodule

// File: test/sdc_config_checker_assertions.sv
// concurrent checks on the ports of the configuration top
module sdc_config_checker #(
	parameter FB_W = 7,
	parameter SHIFT_W = 12,
	parameter MON_W = 10
) (
	input wire sys_clk,
	input wire reset,
	input wire vco_clk,
	input wire ref_clk,
	input wire serial_load,
	input wire parallel_load,
	input wire [FB_W-1:0] feedback_div_in,
	input wire [1:0] post_div_sel_in,
	input wire frequency_reduce_request,
	input wire [FB_W-1:0] feedback_div_value,
	input wire [1:0] post_div_sel,
	input wire [2:0] test_sel,
	input wire [2:0] freq_step,
	input wire [2:0] active_exp,
	input wire synthesized_output,
	input wire feedback_tick,
	input wire test_output
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// windows allow for the two-stage pin synchronisers
	property p_par_follow;
		(!parallel_load && $stable(feedback_div_in) && $stable(post_div_sel_in))[*5]
			|-> feedback_div_value == feedback_div_in && post_div_sel == post_div_sel_in;
	endproperty
	a_par_follow: assert property (p_par_follow) else $error("latch not following pins");
	property p_par_hold;
		(parallel_load && !serial_load)[*6] |-> $stable(feedback_div_value) && $stable(post_div_sel);
	endproperty
	a_par_hold: assert property (p_par_hold) else $error("latch moved after load rise");
	property p_par_wins; (!parallel_load)[*6] |-> $stable(test_sel); endproperty
	a_par_wins: assert property (p_par_wins) else $error("test field moved under parallel");
	property p_ser_hold; (!serial_load)[*6] |-> $stable(test_sel); endproperty
	a_ser_hold: assert property (p_ser_hold) else $error("test field moved after freeze");
	property p_step_paced; (!ref_clk)[*6] |=> $stable(freq_step); endproperty
	a_step_paced: assert property (p_step_paced) else $error("step without reference");
	property p_step_unit;
		$changed(freq_step) |-> freq_step == $past(freq_step) + 3'h1
			|| $past(freq_step) == freq_step + 3'h1;
	endproperty
	a_step_unit: assert property (p_step_unit) else $error("step jumped");
	property p_step_up; frequency_reduce_request[*8] |=> freq_step >= $past(freq_step); endproperty
	a_step_up: assert property (p_step_up) else $error("step fell under request");
	property p_step_dn; (!frequency_reduce_request)[*8] |=> freq_step <= $past(freq_step); endproperty
	a_step_dn: assert property (p_step_dn) else $error("step rose without request");
	property p_tick_pulse; feedback_tick |=> !feedback_tick; endproperty
	a_tick_pulse: assert property (p_tick_pulse) else $error("tick longer than one cycle");
	property p_test_high; (test_sel == 3'h6)[*3] |-> test_output; endproperty
	a_test_high: assert property (p_test_high) else $error("test output not high");
	property p_test_quiet; (test_sel == 3'h0)[*3] |-> !test_output; endproperty
	a_test_quiet: assert property (p_test_quiet) else $error("test output not quiet");
	property p_bypass; (active_exp == 3'h0)[*8] |-> synthesized_output == $past(vco_clk, 3); endproperty
	a_bypass: assert property (p_bypass) else $error("divide by one not following vco");
	c_full_step: cover property (freq_step == 3'h4);
	c_ser_load: cover property ($fell(serial_load));
	c_tick: cover property (feedback_tick);
endmodule

// File: test/sdc_host_model.sv
// host model driving the three-wire serial configuration pins
module sdc_host_model (
	input wire sys_clk,
	output logic serial_clock,
	output logic serial_data,
	output logic serial_load
);
	timeunit 1ns;
	timeprecision 100ps;
	// clock idles low between frames, data rests at its pull-down level
	initial begin
		serial_clock = 1'b0;
		serial_data = 1'b0;
		serial_load = 1'b0;
	end
	task automatic send_word(input logic [11:0] w);
		for (int b = 11; b >= 0; b--) begin
			serial_data <= w[b];
			repeat (4) @(posedge sys_clk);
			serial_clock <= 1'b1;
			repeat (4) @(posedge sys_clk);
			serial_clock <= 1'b0;
		end
		repeat (4) @(posedge sys_clk);
		serial_data <= 1'b0;
	endtask
	task automatic set_load(input logic v);
		serial_load <= v;
		repeat (8) @(posedge sys_clk);
	endtask
endmodule

// File: test/sdc_config_top_tb_top.sv
// testbench top: pins, free clocks, host model and checks for the divider logic
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; \
	$display("[ERR] %0t got %0h want %0h", $time, a, e); end end

module sdc_config_top_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic ref_clk = 1'b0;
	logic vco_clk = 1'b1;
	// driven from the stimulus process only, starting values set there
	logic parallel_load;
	logic reduce;
	logic [6:0] fb_in;
	logic [1:0] sel_in;
	wire serial_clock, serial_data, serial_load, out, tick, tout;
	wire [6:0] fb_val;
	wire [1:0] sel;
	wire [2:0] tsel, step, aexp;
	wire [9:0] vpr;
	int n_fail = 0;
	int check_count = 0;
	int per, hi;
	int base_of[4] = '{1, 2, 3, 0};
	// vco and reference rising edges never coincide, so counts stay exact
	always #5 sys_clk = ~sys_clk;
	always #40 vco_clk = ~vco_clk;
	always #200 ref_clk = ~ref_clk;
	sdc_config_top sdc_config_top_i (
		.sys_clk(sys_clk), .reset(reset), .ref_clk(ref_clk), .vco_clk(vco_clk),
		.serial_clock(serial_clock), .serial_data(serial_data), .serial_load(serial_load),
		.parallel_load(parallel_load), .feedback_div_in(fb_in), .post_div_sel_in(sel_in),
		.frequency_reduce_request(reduce), .feedback_div_value(fb_val), .post_div_sel(sel),
		.test_sel(tsel), .freq_step(step), .active_exp(aexp), .synthesized_output(out),
		.feedback_tick(tick), .vco_per_ref(vpr), .test_output(tout)
	);
	sdc_host_model sdc_host_model_i (.sys_clk(sys_clk), .serial_clock(serial_clock),
		.serial_data(serial_data), .serial_load(serial_load));
	task automatic close_out();
		$display("counts: %0d checks, %0d mismatches", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic par_load(input logic [6:0] f, input logic [1:0] s);
		parallel_load <= 1'b0;
		fb_in <= f;
		sel_in <= s;
		wait_cyc(6);
		`CHK(fb_val, f)
		parallel_load <= 1'b1;
		wait_cyc(6);
	endtask
	// bounded count of cycles while the watched output holds v
	task automatic run_while(input bit use_tick, input logic v, inout int cnt);
		while ((use_tick ? tick : out) === v) begin
			@(negedge sys_clk);
			cnt++;
			if (cnt > 4000) begin
				n_fail++;
				close_out();
			end
		end
	endtask
	task automatic measure(input bit use_tick);
		int a;
		a = 0;
		run_while(use_tick, 1'b1, a);
		run_while(use_tick, 1'b0, a);
		a = 0;
		run_while(use_tick, 1'b1, a);
		hi = a;
		run_while(use_tick, 1'b0, a);
		per = a;
	endtask
	// request set mid reference period so the next rise is the first step
	task automatic steps(input logic req);
		@(posedge ref_clk);
		wait_cyc(10);
		reduce <= req;
		for (int i = 1; i <= 4; i++) begin
			@(posedge ref_clk);
			wait_cyc(10);
			`CHK(step, req ? 3'(i) : 3'(4 - i))
		end
		wait_cyc(1100);
		measure(1'b0);
		`CHK(per, req ? 128 : 8)
		`CHK(aexp, req ? 3'h4 : 3'h0)
	endtask
	initial begin
		parallel_load <= 1'b0;
		reduce <= 1'b0;
		fb_in <= 7'h7f;
		sel_in <= 2'h3;
		wait_cyc(19);
		`CHK(fb_val, 7'h7f)
		`CHK(sel, 2'h3)
		`CHK(tsel, 3'h0)
		@(posedge sys_clk);
		reset <= 1'b0;
		par_load(7'h25, 2'h1);
		fb_in <= 7'h5a;
		wait_cyc(6);
		`CHK(fb_val, 7'h25)
		`CHK(sel, 2'h1)
		$display("parallel test done");
		sdc_host_model_i.send_word(12'hd13);
		sdc_host_model_i.set_load(1'b1);
		`CHK(tsel, 3'h6)
		sdc_host_model_i.set_load(1'b0);
		`CHK(fb_val, 7'h13)
		`CHK(sel, 2'h2)
		`CHK(tout, 1'b1)
		sdc_host_model_i.send_word(12'h0a5);
		`CHK(fb_val, 7'h13)
		sdc_host_model_i.set_load(1'b1);
		`CHK(fb_val, 7'h25)
		`CHK(tout, 1'b0)
		parallel_load <= 1'b0;
		fb_in <= 7'h40;
		wait_cyc(6);
		`CHK(fb_val, 7'h40)
		sdc_host_model_i.set_load(1'b0);
		parallel_load <= 1'b1;
		$display("serial test done");
		for (int k = 0; k < 4; k++) begin
			par_load(7'h05, 2'(k));
			wait_cyc(1100);
			measure(1'b0);
			`CHK(per, 8 << base_of[k])
			`CHK(hi, 4 << base_of[k])
		end
		measure(1'b1);
		`CHK(per, 40)
		`CHK(vpr, 10'd5)
		$display("divider test done");
		steps(1'b1);
		steps(1'b0);
		$display("power down test done");
		close_out();
	end
endmodule

bind sdc_config_top sdc_config_checker #(.FB_W(FB_W), .SHIFT_W(SHIFT_W), .MON_W(MON_W))
	sdc_config_checker_i (.sys_clk, .reset, .vco_clk, .ref_clk, .serial_load, .parallel_load,
	.feedback_div_in, .post_div_sel_in, .frequency_reduce_request, .feedback_div_value,
	.post_div_sel, .test_sel, .freq_step, .active_exp, .synthesized_output, .feedback_tick,
	.test_output);
